// ### core/diag_monitor_readback.v
`timescale 1ns/1ps
`include "diag_monitor_readback_regs.vh"
// Read-only bank of diagnostic monitor results behind an APB slave.
// Converter results arrive tagged by channel identifier on the same clock.
//
// Behaviour in brief
// - Seven monitored quantities each keep one 12-bit result. Software sees
//   every result as a pair of byte registers: the high register holds
//   result bits 11 to 4, and the low register holds bits 3 to 0 in its
//   upper nibble. The lower nibble of each low register is a fixed channel
//   identifier, so a low register never reads as all zeros.
// - The identifiers are also the tags that the converter puts on its
//   results. One capture block per quantity compares the tag with its own
//   identifier, so adding a quantity means adding one instance and two
//   decode branches, plus a result wire and three defines (two indices, one identifier) in the header.
// - A single hold bit freezes every capture block at once. While it is set,
//   new converter results are dropped rather than queued. Software that
//   needs a high byte and a low nibble from the same conversion sets the
//   hold bit, reads both registers and then clears it again.
// - Without the hold bit a result can change between the two reads of a
//   pair. Each capture block stores the whole word in one edge, so the
//   two halves are consistent inside the block; only the two separate bus
//   reads can straddle an update.
//
// Bus behaviour
// - The slave answers with zero wait states. Read data and the error flag
//   are registered at the setup edge and held until the next setup edge,
//   so the access cycle only has to raise pready.
// - A result that lands during the access cycle of a read is not in that
//   read's data; it shows on the next read. This trades one cycle of
//   latency for a registered read path with no combinational bus output
//   other than pready.
// - Writes to result registers complete without an error and change
//   nothing. Unmapped indices and byte-offset addresses answer with an
//   error and read as zero. Neither kind of access changes any state.
// - Only the hold register takes writes, and only when byte strobe 0 is
//   set, because the hold bit sits in the lowest byte of the word.
//
// Limitations
// - Result widths other than 12 bits need a matching pair_read function;
//   the register layout itself is fixed at a high byte and a low nibble.
// - The converter strobe must be on this clock. A converter on another
//   clock needs its own crossing in front of this block.
// - There is no interrupt and no new-data flag; software polls.
module diag_monitor_readback #(
  parameter RESULT_WIDTH = 12
) (
  input  wire                       ref_clk_in,
  input  wire                       rst_in,
  input  wire                       psel_in,
  input  wire                       penable_in,
  input  wire                       pwrite_in,
  input  wire [`DMR_ADDR_WIDTH-1:0] paddr_in,
  input  wire [31:0]                pwdata_in,
  input  wire [3:0]                 pstrb_in,
  output wire                       pready_out,
  output reg  [31:0]                prdata_out,
  output reg                        pslverr_out,
  input  wire                       sample_valid_in,
  input  wire [3:0]                 sample_channel_in,
  input  wire [RESULT_WIDTH-1:0]    sample_data_in,
  output wire                       freeze_result_update_out
);

  // Hold control bit written by software
  reg                        freeze_result_update;

  // Stored results, one per monitored quantity
  wire [RESULT_WIDTH-1:0]    out1_pos_result;
  wire [RESULT_WIDTH-1:0]    out1_neg_result;
  wire [RESULT_WIDTH-1:0]    out2_pos_result;
  wire [RESULT_WIDTH-1:0]    out2_neg_result;
  wire [RESULT_WIDTH-1:0]    temperature_result;
  wire [RESULT_WIDTH-1:0]    analog_supply_result;
  wire [RESULT_WIDTH-1:0]    gp_input_result;

  // Bus decode terms
  wire [`DMR_IDX_WIDTH-1:0]  reg_index;   // Word index of the access
  wire                       aligned;     // Low address bits are zero
  wire                       setup_phase; // First cycle of a transfer
  wire                       access_done; // Edge at which transfer ends

  // Next values of the read path
  reg  [7:0]                 next_rdata;
  reg                        next_err;

  assign reg_index   = paddr_in[`DMR_ADDR_WIDTH-1:2];
  assign aligned     = (paddr_in[1:0] == 2'b00);
  assign setup_phase = psel_in && !penable_in;
  assign access_done = psel_in && penable_in;

  // Zero wait states: the answer is prepared during the setup cycle
  assign pready_out = psel_in && penable_in;

  assign freeze_result_update_out = freeze_result_update;

  // Result pair read: high register carries bits 11-4, low register
  // carries bits 3-0 above the fixed identifier
  function [7:0] pair_read;
    input [11:0] result;
    input [3:0]  channel_id;
    input        low_half;
    begin
      if (low_half) begin
        pair_read = {result[3:0], channel_id};
      end else begin
        pair_read = result[11:4];
      end
    end
  endfunction

  // One capture block per quantity, each listening for its identifier
  // Output 1, positive leg; its pair sits just below the negative leg
  // so that the two legs of one output read as four adjacent words
  diag_result_capture #(
    .CHANNEL_ID   (`DMR_ID_OUT1P),
    .RESULT_WIDTH (RESULT_WIDTH)
  ) u_out1_pos (
    .ref_clk_in        (ref_clk_in),
    .rst_in            (rst_in),
    .sample_valid_in   (sample_valid_in),
    .sample_channel_in (sample_channel_in),
    .sample_data_in    (sample_data_in),
    .freeze_in         (freeze_result_update),
    .result_out        (out1_pos_result)
  );

  // Output 1, negative leg
  // Shares the converter strobe with every other quantity
  diag_result_capture #(
    .CHANNEL_ID   (`DMR_ID_OUT1N),
    .RESULT_WIDTH (RESULT_WIDTH)
  ) u_out1_neg (
    .ref_clk_in        (ref_clk_in),
    .rst_in            (rst_in),
    .sample_valid_in   (sample_valid_in),
    .sample_channel_in (sample_channel_in),
    .sample_data_in    (sample_data_in),
    .freeze_in         (freeze_result_update),
    .result_out        (out1_neg_result)
  );

  // Output 2, positive leg
  // Same layout as output 1, identifiers one pair higher
  diag_result_capture #(
    .CHANNEL_ID   (`DMR_ID_OUT2P),
    .RESULT_WIDTH (RESULT_WIDTH)
  ) u_out2_pos (
    .ref_clk_in        (ref_clk_in),
    .rst_in            (rst_in),
    .sample_valid_in   (sample_valid_in),
    .sample_channel_in (sample_channel_in),
    .sample_data_in    (sample_data_in),
    .freeze_in         (freeze_result_update),
    .result_out        (out2_pos_result)
  );

  // Output 2, negative leg
  // Last of the four output legs
  diag_result_capture #(
    .CHANNEL_ID   (`DMR_ID_OUT2N),
    .RESULT_WIDTH (RESULT_WIDTH)
  ) u_out2_neg (
    .ref_clk_in        (ref_clk_in),
    .rst_in            (rst_in),
    .sample_valid_in   (sample_valid_in),
    .sample_channel_in (sample_channel_in),
    .sample_data_in    (sample_data_in),
    .freeze_in         (freeze_result_update),
    .result_out        (out2_neg_result)
  );

  // Die temperature
  // Frozen by the same hold bit as the output legs
  diag_result_capture #(
    .CHANNEL_ID   (`DMR_ID_TEMP),
    .RESULT_WIDTH (RESULT_WIDTH)
  ) u_temperature (
    .ref_clk_in        (ref_clk_in),
    .rst_in            (rst_in),
    .sample_valid_in   (sample_valid_in),
    .sample_channel_in (sample_channel_in),
    .sample_data_in    (sample_data_in),
    .freeze_in         (freeze_result_update),
    .result_out        (temperature_result)
  );

  // Analog supply
  // Its pair follows a two-word hole after the temperature pair
  diag_result_capture #(
    .CHANNEL_ID   (`DMR_ID_SUPPLY),
    .RESULT_WIDTH (RESULT_WIDTH)
  ) u_analog_supply (
    .ref_clk_in        (ref_clk_in),
    .rst_in            (rst_in),
    .sample_valid_in   (sample_valid_in),
    .sample_channel_in (sample_channel_in),
    .sample_data_in    (sample_data_in),
    .freeze_in         (freeze_result_update),
    .result_out        (analog_supply_result)
  );

  // General-purpose analog input
  // Highest pair of the bank
  diag_result_capture #(
    .CHANNEL_ID   (`DMR_ID_GPIN),
    .RESULT_WIDTH (RESULT_WIDTH)
  ) u_gp_input (
    .ref_clk_in        (ref_clk_in),
    .rst_in            (rst_in),
    .sample_valid_in   (sample_valid_in),
    .sample_channel_in (sample_channel_in),
    .sample_data_in    (sample_data_in),
    .freeze_in         (freeze_result_update),
    .result_out        (gp_input_result)
  );

  // Read decode; nothing here changes state, so a read has no side effect
  // The decode runs on every cycle but is only captured at a setup edge,
  // so glitches on the address between transfers never reach the bus.
  // Writes pass through the same decode; their read data is simply unused.
  always @* begin
    next_rdata = 8'h00;
    next_err   = 1'b0;
    if (!aligned) begin
      // Byte-offset access is not a register
      next_err = 1'b1;
    end else if (reg_index == `DMR_IDX_HOLD_CFG) begin
      next_rdata[`DMR_HOLD_BIT] = freeze_result_update;
    end else if (reg_index == `DMR_IDX_OUT1P_HIGH) begin
      next_rdata = pair_read(out1_pos_result, `DMR_ID_OUT1P, 1'b0);
    end else if (reg_index == `DMR_IDX_OUT1P_LOW) begin
      next_rdata = pair_read(out1_pos_result, `DMR_ID_OUT1P, 1'b1);
    end else if (reg_index == `DMR_IDX_OUT1N_HIGH) begin
      next_rdata = pair_read(out1_neg_result, `DMR_ID_OUT1N, 1'b0);
    end else if (reg_index == `DMR_IDX_OUT1N_LOW) begin
      next_rdata = pair_read(out1_neg_result, `DMR_ID_OUT1N, 1'b1);
    end else if (reg_index == `DMR_IDX_OUT2P_HIGH) begin
      next_rdata = pair_read(out2_pos_result, `DMR_ID_OUT2P, 1'b0);
    end else if (reg_index == `DMR_IDX_OUT2P_LOW) begin
      next_rdata = pair_read(out2_pos_result, `DMR_ID_OUT2P, 1'b1);
    end else if (reg_index == `DMR_IDX_OUT2N_HIGH) begin
      next_rdata = pair_read(out2_neg_result, `DMR_ID_OUT2N, 1'b0);
    end else if (reg_index == `DMR_IDX_OUT2N_LOW) begin
      next_rdata = pair_read(out2_neg_result, `DMR_ID_OUT2N, 1'b1);
    end else if (reg_index == `DMR_IDX_TEMP_HIGH) begin
      next_rdata = pair_read(temperature_result, `DMR_ID_TEMP, 1'b0);
    end else if (reg_index == `DMR_IDX_TEMP_LOW) begin
      next_rdata = pair_read(temperature_result, `DMR_ID_TEMP, 1'b1);
    end else if (reg_index == `DMR_IDX_SUPPLY_HIGH) begin
      next_rdata = pair_read(analog_supply_result, `DMR_ID_SUPPLY, 1'b0);
    end else if (reg_index == `DMR_IDX_SUPPLY_LOW) begin
      next_rdata = pair_read(analog_supply_result, `DMR_ID_SUPPLY, 1'b1);
    end else if (reg_index == `DMR_IDX_GPIN_HIGH) begin
      next_rdata = pair_read(gp_input_result, `DMR_ID_GPIN, 1'b0);
    end else if (reg_index == `DMR_IDX_GPIN_LOW) begin
      next_rdata = pair_read(gp_input_result, `DMR_ID_GPIN, 1'b1);
    end else begin
      // Unmapped word: reads zero and reports an error
      next_err = 1'b1;
    end
  end

  // Answer registered at the setup edge; the gap between 0x6B and 0x6E
  // is unmapped and errors like any other hole
  always @(posedge ref_clk_in) begin
    if (rst_in) begin
      prdata_out  <= 32'h0000_0000;
      pslverr_out <= 1'b0;
    end else if (setup_phase) begin
      // Upper bits of the word always read as zero
      prdata_out  <= {24'h00_0000, next_rdata};
      pslverr_out <= next_err;
    end
  end

  // Hold control write; result registers have no write path at all, so
  // writes aimed at them complete without error and change nothing
  always @(posedge ref_clk_in) begin
    if (rst_in) begin
      freeze_result_update <= `DMR_HOLD_RESET;
    end else if (access_done && pwrite_in && aligned && pstrb_in[0] &&
                 (reg_index == `DMR_IDX_HOLD_CFG)) begin
      freeze_result_update <= pwdata_in[`DMR_HOLD_BIT];
    end
  end

endmodule

// ### core/diag_monitor_readback_regs.vh
// Operation
// - High register holds result bits 11 to 4
// - Low register bits 7-4 hold result bits 3-0
// - Output 1 identifiers 0110b and 0111b
// - Output 2 identifiers 1000b and 1001b
// - Temperature pair at 0x6A/0x6B, identifier 1010b
// - Supply pair at 0x6E/0x6F, identifier 1100b
// - Input high byte at 0x70, resets zero
// - Input low register 0x71, identifier 1101b
// - Hold bit freezes result updates
`ifndef DIAG_MONITOR_READBACK_REGS_VH
`define DIAG_MONITOR_READBACK_REGS_VH

// Register indices; byte address is four times the index
`define DMR_IDX_HOLD_CFG       8'h55
`define DMR_IDX_OUT1P_HIGH     8'h62
`define DMR_IDX_OUT1P_LOW      8'h63
`define DMR_IDX_OUT1N_HIGH     8'h64
`define DMR_IDX_OUT1N_LOW      8'h65
`define DMR_IDX_OUT2P_HIGH     8'h66
`define DMR_IDX_OUT2P_LOW      8'h67
`define DMR_IDX_OUT2N_HIGH     8'h68
`define DMR_IDX_OUT2N_LOW      8'h69
`define DMR_IDX_TEMP_HIGH      8'h6a
`define DMR_IDX_TEMP_LOW       8'h6b
`define DMR_IDX_SUPPLY_HIGH    8'h6e
`define DMR_IDX_SUPPLY_LOW     8'h6f
`define DMR_IDX_GPIN_HIGH      8'h70
`define DMR_IDX_GPIN_LOW       8'h71

// Fixed channel identifiers, low register bits 3 to 0
`define DMR_ID_OUT1P           4'h6
`define DMR_ID_OUT1N           4'h7
`define DMR_ID_OUT2P           4'h8
`define DMR_ID_OUT2N           4'h9
`define DMR_ID_TEMP            4'ha
`define DMR_ID_SUPPLY          4'hc
`define DMR_ID_GPIN            4'hd

// Field layout
`define DMR_HOLD_BIT           0
`define DMR_HOLD_RESET         1'b0
`define DMR_RESULT_RESET       12'h000
`define DMR_RESULT_WIDTH       12
`define DMR_IDX_WIDTH          8
`define DMR_ADDR_WIDTH         10

`endif

// ### core/diag_result_capture.v
`timescale 1ns/1ps
// One monitored quantity: keeps the latest 12-bit result tagged with its
// channel identifier, unless updates are frozen.
module diag_result_capture #(
  parameter [3:0] CHANNEL_ID   = 4'h0,
  parameter       RESULT_WIDTH = 12
) (
  input  wire                    ref_clk_in,
  input  wire                    rst_in,
  input  wire                    sample_valid_in,
  input  wire [3:0]              sample_channel_in,
  input  wire [RESULT_WIDTH-1:0] sample_data_in,
  input  wire                    freeze_in,
  output reg  [RESULT_WIDTH-1:0] result_out
);

  // Sample belongs to this quantity
  wire hit;

  assign hit = sample_valid_in && (sample_channel_in == CHANNEL_ID);

  // Result store; the whole word updates at once so high and low halves
  // always come from the same conversion
  always @(posedge ref_clk_in) begin
    if (rst_in) begin
      result_out <= {RESULT_WIDTH{1'b0}};
    end else if (hit && !freeze_in) begin
      result_out <= sample_data_in;
    end
  end

endmodule

// ### dv/diag_monitor_readback_bench.sv
`timescale 1ns/1ps
// Self-checking bench for the monitor result bank
module diag_monitor_readback_bench;
  logic        ref_clk = 1'b0;   // 100 MHz clock
  logic        rst = 1'b1;       // Synchronous reset, high
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [9:0]  paddr = 10'h0;
  logic [31:0] pwdata = 32'h0;
  logic        pready;
  logic [31:0] prdata;
  logic        pslverr;
  logic        sv = 1'b0;        // Converter strobe
  logic [3:0]  sc = 4'h0;        // Converter channel identifier
  logic [11:0] sd = 12'h0;       // Converter result
  logic        freeze;
  logic [31:0] rd;               // Last read data
  logic        er;               // Last error flag
  int          failures = 0;
  int          total_checks = 0;
  int          cyc = 0;
  // High register index and identifier of each quantity
  logic [7:0]  hi [7] = '{8'h62, 8'h64, 8'h66, 8'h68, 8'h6a, 8'h6e, 8'h70};
  logic [3:0]  ids [7] = '{4'h6, 4'h7, 4'h8, 4'h9, 4'ha, 4'hc, 4'hd};
  diag_monitor_readback u_diag_monitor_readback (
    .ref_clk_in(ref_clk), .rst_in(rst), .psel_in(psel), .penable_in(penable),
    .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata), .pstrb_in(4'hf),
    .pready_out(pready), .prdata_out(prdata), .pslverr_out(pslverr),
    .sample_valid_in(sv), .sample_channel_in(sc), .sample_data_in(sd),
    .freeze_result_update_out(freeze));
  always #5 ref_clk = ~ref_clk;
  // Cut a hang short; the whole run needs about 150 cycles
  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      failures++;
      test_done;
    end
  end
  task automatic test_done;
    if (failures == 0 && total_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", n, e, g);
    end
  endtask
  // One APB transfer; the request holds until pready is seen high
  task automatic apb(input logic w, input logic [9:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    do @(posedge ref_clk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rdchk(input logic [7:0] ix, input logic [31:0] e, input string n);
    apb(1'b0, {ix, 2'b00}, 32'h0);
    chk(n, e, rd);
  endtask
  // One converter result, strobed for a single cycle
  task automatic smp(input logic [3:0] c, input logic [11:0] d);
    @(posedge ref_clk);
    sv <= 1'b1;
    sc <= c;
    sd <= d;
    @(posedge ref_clk);
    sv <= 1'b0;
  endtask
  task automatic t_reset;
    for (int i = 0; i < 7; i++) begin
      rdchk(hi[i], 32'h0, "high_reset");
      rdchk(hi[i] + 8'h1, {28'h0, ids[i]}, "low_reset");
    end
  endtask
  // Every channel gets a distinct result, read back as both halves
  task automatic t_update;
    logic [11:0] v;
    for (int i = 0; i < 7; i++) begin
      v = {ids[i], ~ids[i], ids[i] + 4'h3};
      smp(ids[i], v);
      rdchk(hi[i], {24'h0, v[11:4]}, "high_byte");
      rdchk(hi[i] + 8'h1, {24'h0, v[3:0], ids[i]}, "low_nibble");
    end
  endtask
  // Frozen results ignore new samples until the hold bit clears
  task automatic t_hold;
    apb(1'b1, 10'h154, 32'h1);
    @(negedge ref_clk);
    chk("freeze", 32'h1, {31'h0, freeze});
    smp(4'ha, 12'h3c1);
    rdchk(8'h6a, 32'ha5, "held_high");
    rdchk(8'h55, 32'h1, "hold_readback");
    apb(1'b1, 10'h154, 32'h0);
    smp(4'ha, 12'h3c1);
    rdchk(8'h6b, 32'h1a, "live_low");
  endtask
  // Result writes are ignored; unmapped and misaligned are refused
  task automatic t_ro;
    apb(1'b1, 10'h1ac, 32'hff);
    chk("ro_err", 32'h0, {31'h0, er});
    rdchk(8'h6b, 32'h1a, "ro_keep");
    apb(1'b0, 10'h1b0, 32'h0);
    chk("unmapped_err", 32'h1, {31'h0, er});
    apb(1'b0, 10'h1a9, 32'h0);
    chk("misalign_err", 32'h1, {31'h0, er});
    chk("misalign_data", 32'h0, rd);
  endtask
  initial begin
    repeat (16) @(posedge ref_clk);
    rst <= 1'b0;
    t_reset;
    t_update;
    t_hold;
    t_ro;
    test_done;
  end
endmodule

// ### dv/diag_monitor_readback_checker.sv
`timescale 1ns/1ps
`include "diag_monitor_readback_regs.vh"
// Port-level watcher for the monitor result bank
module diag_monitor_readback_checker #(
  parameter RESULT_WIDTH = 12
) (
  input wire logic                    ref_clk_in,
  input wire logic                    rst_in,
  input wire logic                    psel_in,
  input wire logic                    penable_in,
  input wire logic                    pwrite_in,
  input wire logic [9:0]              paddr_in,
  input wire logic [31:0]             pwdata_in,
  input wire logic [3:0]              pstrb_in,
  input wire logic                    pready_out,
  input wire logic [31:0]             prdata_out,
  input wire logic                    pslverr_out,
  input wire logic                    sample_valid_in,
  input wire logic [3:0]              sample_channel_in,
  input wire logic [RESULT_WIDTH-1:0] sample_data_in,
  input wire logic                    freeze_result_update_out
);
  // Setup phase, word index and a strobed write to the hold register
  wire       setup   = psel_in & ~penable_in;
  wire [7:0] ix      = paddr_in[9:2];
  wire       hold_wr = psel_in & penable_in & pwrite_in & pstrb_in[0] & (paddr_in == 10'h154);
  default clocking @(posedge ref_clk_in); endclocking
  default disable iff (rst_in);
  // Identifier of a low register, f where the index is no low register
  function automatic [3:0] idf(input [7:0] i);
    case (i)
      8'h63: idf = 4'h6;
      8'h65: idf = 4'h7;
      8'h67: idf = 4'h8;
      8'h69: idf = 4'h9;
      8'h6b: idf = 4'ha;
      8'h6f: idf = 4'hc;
      8'h71: idf = 4'hd;
      default: idf = 4'hf;
    endcase
  endfunction
  property p_upper_zero;
    setup |=> prdata_out[31:8] == 24'h0;
  endproperty
  a_upper_zero: assert property (p_upper_zero) else $error("read data upper bits set");
  property p_low_id;
    setup && paddr_in[1:0] == 2'b0 && idf(ix) != 4'hf |=> prdata_out[3:0] == $past(idf(ix));
  endproperty
  a_low_id: assert property (p_low_id) else $error("wrong channel identifier");
  // A gap cycle without a new sample keeps the expected value exact
  property p_temp_high;
    sample_valid_in && sample_channel_in == 4'ha && !freeze_result_update_out ##1
      !sample_valid_in ##1 setup && paddr_in == 10'h1a8
      |=> prdata_out[7:0] == $past(sample_data_in[11:4], 3);
  endproperty
  a_temp_high: assert property (p_temp_high) else $error("temperature high byte stale");
  property p_hold_write;
    hold_wr |=> freeze_result_update_out == $past(pwdata_in[0]);
  endproperty
  a_hold_write: assert property (p_hold_write) else $error("hold bit not written");
  property p_hold_keep;
    !hold_wr |=> $stable(freeze_result_update_out);
  endproperty
  a_hold_keep: assert property (p_hold_keep) else $error("hold bit changed alone");
  property p_reset_clear;
    $fell(rst_in) |-> !freeze_result_update_out && prdata_out == 32'h0 && !pslverr_out;
  endproperty
  a_reset_clear: assert property (p_reset_clear) else $error("state not cleared by reset");
  property p_misalign;
    setup && paddr_in[1:0] != 2'b0 |=> pslverr_out && prdata_out == 32'h0;
  endproperty
  a_misalign: assert property (p_misalign) else $error("misaligned access accepted");
  property p_ro_ok;
    setup && pwrite_in && paddr_in[1:0] == 2'b0 && idf(ix) != 4'hf |=> !pslverr_out;
  endproperty
  a_ro_ok: assert property (p_ro_ok) else $error("result write flagged error");
  c_hold: cover property (hold_wr);
  c_misalign: cover property (setup && paddr_in[1:0] != 2'b0);
  c_live: cover property (sample_valid_in && !freeze_result_update_out);
endmodule
bind diag_monitor_readback diag_monitor_readback_checker #(.RESULT_WIDTH(RESULT_WIDTH)) u_chk (
  .ref_clk_in(ref_clk_in), .rst_in(rst_in), .psel_in(psel_in), .penable_in(penable_in),
  .pwrite_in(pwrite_in), .paddr_in(paddr_in), .pwdata_in(pwdata_in), .pstrb_in(pstrb_in),
  .pready_out(pready_out), .prdata_out(prdata_out), .pslverr_out(pslverr_out),
  .sample_valid_in(sample_valid_in), .sample_channel_in(sample_channel_in),
  .sample_data_in(sample_data_in), .freeze_result_update_out(freeze_result_update_out));
